// [design/mma_pkg.sv]
// Purpose: constants for the micromirror array addressing block
// Assumes: 100 MHz ref_clk; link clock and pins sampled, not used as clocks
// Notes:   row load format and reset grouping fixed here
// Function
// - one memory bit per mirror, 2D array
// - cell drives true and inverse electrodes
// - mirror moves only on clocking pulse
// - cell one plus pulse gives positive tilt
// - cell zero plus pulse gives negative tilt
// - positive tilt on, negative tilt off
// - mirrors tied to grouped reset pulse lines
// - pixel data on both link clock edges
// - parked array goes flat, tilt uncontrolled
package mma_pkg;
    localparam int COLS           = 1024;
    localparam int ROWS           = 768;
    localparam int CELL_COUNT     = 786432;
    localparam int COL_W          = 10;
    localparam int ROW_W          = 10;
    localparam int LINK_W         = 16;
    localparam int WORDS_PER_ROW  = COLS / LINK_W;
    localparam int WORD_CNT_W     = 6;
    localparam int GROUPS         = 16;
    localparam int ROWS_PER_GROUP = ROWS / GROUPS;
    localparam int GROUP_W        = 4;
    localparam int SYNC_STAGES    = 3;
    // Bit positions of the sampled pin bundle
    localparam int PIN_CLK        = 0;
    localparam int PIN_START      = 1;
    localparam int PIN_VALID      = 2;
    localparam int PIN_PARK       = 3;
    localparam int PIN_DATA       = 4;
    localparam int PIN_GROUP      = PIN_DATA + LINK_W;
    localparam int PIN_W          = PIN_GROUP + GROUPS;
    // Header word carries the row index in its low bits
    localparam int HDR_ROW_LSB    = 0;
    localparam logic TILT_POS     = 1'b1;
    localparam logic TILT_NEG     = 1'b0;
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_LOAD,
        LINK_COMMIT
    } mma_link_state_t;
endpackage

// [design/mma_pin_sync.sv]
// Purpose: three-stage sampler for pins from outside the clock domain
// Assumes: ce freezes all state
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module mma_pin_sync
    import mma_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Raw pins
    input  wire logic [W-1:0] pinRaw,
    // Settled view
    output logic      [W-1:0] settled_q,
    output logic      [W-1:0] changed_q
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else if (ce) begin
            stage1_q <= pinRaw;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Accept a level once two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settled_q <= '0;
            changed_q <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                changed_q[i] <= 1'b0;
                if (stage2_q[i] == stage3_q[i] && stage3_q[i] != settled_q[i]) begin
                    settled_q[i] <= stage3_q[i];
                    changed_q[i] <= 1'b1;
                end
            end
        end
    end
endmodule

// [design/mma_array.sv]
// Purpose: cell array, mirror state and grouped clocking pulses
// Assumes: link clock sampled by ref_clk; reset pulses come from outside
// Notes:   array contents are observed through an indexed read port
`timescale 1ns/1ps
module mma_array
    import mma_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Data link from the controller
    input  wire logic              linkClk,
    input  wire logic              linkStart,
    input  wire logic              linkValid,
    input  wire logic [LINK_W-1:0] linkData,
    // Mirror clocking and park
    input  wire logic [GROUPS-1:0] mirror_group_reset_pulse,
    input  wire logic              mirrorPark,
    // Observation index
    input  wire logic [ROW_W-1:0]  obsRow,
    input  wire logic [COL_W-1:0]  obsCol,
    // Observed state
    output logic                   obsCell_q,
    output logic                   cell_inverse_drive_q,
    output logic                   obsTilt_q,
    output logic                   obsLanded_q,
    output logic                   rowWritten_q,
    output logic [GROUPS-1:0]      groupLanded_q
);
    // Group that owns a row
    function automatic logic [GROUP_W-1:0] groupOf(input int unsigned row);
        groupOf = GROUP_W'(row / ROWS_PER_GROUP);
    endfunction

    logic [PIN_W-1:0]  pinRaw;
    logic [PIN_W-1:0]  pinSettled;
    logic [PIN_W-1:0]  pinChanged;
    logic              linkEdge;
    logic [LINK_W-1:0] linkWord;
    logic [GROUPS-1:0] groupRise;
    logic              parkNow;

    // One memory bit per mirror, row by column
    logic [COLS-1:0]   cellMem_q [ROWS];
    // Landed mirror state, updated only by pulses
    logic [COLS-1:0]   tiltMem_q [ROWS];

    mma_link_state_t   linkState_q;
    logic [ROW_W-1:0]  loadRow_q;
    logic [WORD_CNT_W-1:0] wordCnt_q;
    logic [COLS-1:0]   rowBuf_q;

    assign pinRaw = {mirror_group_reset_pulse, linkData, mirrorPark,
                     linkValid, linkStart, linkClk};

    mma_pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pinRaw   (pinRaw),
        .settled_q(pinSettled),
        .changed_q(pinChanged)
    );

    // Both link clock edges carry a word
    assign linkEdge  = pinChanged[PIN_CLK];
    assign linkWord  = pinSettled[PIN_DATA +: LINK_W];
    assign groupRise = pinChanged[PIN_GROUP +: GROUPS] & pinSettled[PIN_GROUP +: GROUPS];
    assign parkNow   = pinSettled[PIN_PARK];

    // Row load sequencer: header word, then one row of data words
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkState_q  <= LINK_IDLE;
            loadRow_q    <= '0;
            wordCnt_q    <= '0;
            rowBuf_q     <= '0;
            rowWritten_q <= 1'b0;
        end else if (ce) begin
            rowWritten_q <= 1'b0;
            case (linkState_q)
                LINK_IDLE: begin
                    if (linkEdge && pinSettled[PIN_START]) begin
                        loadRow_q   <= linkWord[HDR_ROW_LSB +: ROW_W];
                        wordCnt_q   <= '0;
                        linkState_q <= LINK_LOAD;
                    end
                end
                LINK_LOAD: begin
                    if (linkEdge && pinSettled[PIN_START]) begin
                        loadRow_q <= linkWord[HDR_ROW_LSB +: ROW_W];
                        wordCnt_q <= '0;
                    end else if (linkEdge && pinSettled[PIN_VALID]) begin
                        rowBuf_q[wordCnt_q * LINK_W +: LINK_W] <= linkWord;
                        wordCnt_q <= wordCnt_q + 1'b1;
                        if (wordCnt_q == WORD_CNT_W'(WORDS_PER_ROW - 1)) begin
                            linkState_q <= LINK_COMMIT;
                        end
                    end
                end
                LINK_COMMIT: begin
                    rowWritten_q <= (int'(loadRow_q) < ROWS);
                    linkState_q  <= LINK_IDLE;
                end
                default: begin
                    linkState_q <= LINK_IDLE;
                end
            endcase
        end
    end

    // Cell write; mirrors do not follow it
    always_ff @(posedge ref_clk) begin
        if (ce && linkState_q == LINK_COMMIT && int'(loadRow_q) < ROWS) begin
            cellMem_q[loadRow_q] <= rowBuf_q;
        end
    end

    // Pulse copies cells to mirrors of the pulsed groups only
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            for (int r = 0; r < ROWS; r++) begin
                if (groupRise[groupOf(r)]) begin
                    tiltMem_q[r] <= cellMem_q[r];
                end
            end
        end
    end

    // Landed per group; park drops every group to flat
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            groupLanded_q <= '0;
        end else if (ce) begin
            if (parkNow) begin
                groupLanded_q <= '0;
            end else begin
                groupLanded_q <= groupLanded_q | groupRise;
            end
        end
    end

    // Observation of one cell, its inverse, and its mirror
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            obsCell_q            <= 1'b0;
            cell_inverse_drive_q <= 1'b1;
            obsTilt_q            <= TILT_NEG;
            obsLanded_q          <= 1'b0;
        end else if (ce) begin
            if (int'(obsRow) < ROWS) begin
                obsCell_q            <= cellMem_q[obsRow][obsCol];
                cell_inverse_drive_q <= ~cellMem_q[obsRow][obsCol];
                // One lands positive (on), zero negative (off)
                obsTilt_q   <= tiltMem_q[obsRow][obsCol] ? TILT_POS : TILT_NEG;
                obsLanded_q <= groupLanded_q[groupOf(int'(obsRow))] & ~parkNow;
            end else begin
                obsCell_q            <= 1'b0;
                cell_inverse_drive_q <= 1'b1;
                obsTilt_q            <= TILT_NEG;
                obsLanded_q          <= 1'b0;
            end
        end
    end
endmodule

// [test/mma_array_properties.sv]
// Purpose: port checks on mma_array
// Assumes: ce held high by the bench
// Notes:   bound to every mma_array
`timescale 1ns/1ps
module mma_array_chk
    import mma_pkg::*;
(
    // Clock and control
    input wire logic              ref_clk, rst_n, ce, linkValid, mirrorPark,
    input wire logic [GROUPS-1:0] mirror_group_reset_pulse, groupLanded_q,
    // Observation
    input wire logic [ROW_W-1:0]  obsRow,
    input wire logic [COL_W-1:0]  obsCol,
    input wire logic              obsCell_q, cell_inverse_drive_q, obsTilt_q,
    input wire logic              obsLanded_q, rowWritten_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] idle_q;
    // Cycles since a data word was last offered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            idle_q <= 5'h1f;
        else
            idle_q <= linkValid ? 5'h00 : idle_q + {4'h0, idle_q != 5'h1f};
    end
    chk_cell_pair:
        assert property (cell_inverse_drive_q == ~obsCell_q) else $error("inverse mismatch");
    chk_reset_state:
        assert property ($rose(rst_n) |-> cell_inverse_drive_q && !obsTilt_q
            && groupLanded_q == 0) else $error("bad reset state");
    chk_tilt_needs_pulse:
        assert property ((mirror_group_reset_pulse == 0 && $stable({obsRow, obsCol})
            && obsLanded_q)[*8] |-> $stable(obsTilt_q)) else $error("tilt moved alone");
    chk_park_clears:
        assert property (mirrorPark[*8] |-> groupLanded_q == 0 && !obsLanded_q)
            else $error("park kept landed");
    chk_row_commit:
        assert property (rowWritten_q |-> idle_q < 5'h14) else $error("commit without data");
    chk_written_pulse:
        assert property (rowWritten_q |=> !rowWritten_q) else $error("commit too long");
    // Per group landing and its cause
    for (genvar g = 0; g < GROUPS; g++) begin : perGroup
        chk_group_lands:
            assert property ($rose(mirror_group_reset_pulse[g]) && !mirrorPark && ce
                |-> ##[3:6] groupLanded_q[g]) else $error("group did not land");
        chk_landed_cause:
            assert property ($rose(groupLanded_q[g]) |-> $past(mirror_group_reset_pulse[g], 3)
                || $past(mirror_group_reset_pulse[g], 4)) else $error("landed unasked");
    end
    cover property (rowWritten_q);
    cover property (groupLanded_q == 16'h0005);
    cover property (mirrorPark && groupLanded_q == 0);
endmodule
bind mma_array mma_array_chk chk (.*);

// [test/mma_ctrl_model.sv]
// Purpose: controller side, row loads and group pulses
// Assumes: link half period 62.5 ns
// Notes:   released data shows inverse of last word
`timescale 1ns/1ps
module mma_ctrl_model
    import mma_pkg::*;
(
    // Clock in, link and pulses out
    input wire logic          ref_clk,
    output logic              linkClk, linkStart, linkValid,
    output logic [LINK_W-1:0] linkData,
    output logic [GROUPS-1:0] mirror_group_reset_pulse
);
    // Binary pattern rate ceiling gives the minimum pulse spacing
    localparam real PULSE_GAP_NS = 1.0e9 / 5000.0;
    realtime        lastPulse    = -1.0e9;
    // Only binary patterns, one per pulse; video, buffer, grayscale
    // and frame slicing sequencing are left to the real controller
    // Idle link, no pulses
    initial begin
        linkClk = 1'b0;
        linkStart = 1'b0;
        linkValid = 1'b0;
        linkData = 16'h0000;
        mirror_group_reset_pulse = 16'h0000;
    end
    // One word per link edge, centred on it
    task automatic put_word(input logic [LINK_W-1:0] w, input logic hdr);
        linkStart = hdr;
        linkValid = !hdr;
        linkData = w;
        #31.25 linkClk = !linkClk;
        #31.25;
    endtask
    // Header then a row, link clock stops after
    task automatic send_row(input int r, input logic [COLS-1:0] bits);
        put_word(LINK_W'(r[ROW_W-1:0]), 1'b1);
        for (int k = 0; k < WORDS_PER_ROW; k++)
            put_word(bits[LINK_W*k +: LINK_W], 1'b0);
        linkValid = 1'b0;
        linkData = ~linkData;
    endtask
    // Clocking pulse made here, held four cycles
    task automatic pulse(input logic [GROUPS-1:0] g);
        while ($realtime - lastPulse < PULSE_GAP_NS)
            @(posedge ref_clk);
        @(posedge ref_clk);
        mirror_group_reset_pulse <= g;
        lastPulse = $realtime;
        repeat (4) @(posedge ref_clk);
        mirror_group_reset_pulse <= 16'h0000;
        repeat (10) @(posedge ref_clk);
    endtask
endmodule

// [test/tb.sv]
// Purpose: self-checking bench for mma_array
// Assumes: ce held high
// Notes:   model keeps cells and mirrors per index
`timescale 1ns/1ps
module tb;
    import mma_pkg::*;
    logic ref_clk, rst_n, ce, mirrorPark;
    logic [ROW_W-1:0] obsRow;
    logic [COL_W-1:0] obsCol;
    wire logic linkClk, linkStart, linkValid;
    wire logic [LINK_W-1:0] linkData;
    wire logic [GROUPS-1:0] mirror_group_reset_pulse;
    logic obsCell_q, cell_inverse_drive_q, obsTilt_q, obsLanded_q, rowWritten_q;
    logic [GROUPS-1:0] groupLanded_q;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    bit cellM [int];
    bit tiltM [int];
    mma_ctrl_model ctrl (.*);
    mma_array DUT (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check(input logic got, input bit exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    // Edge columns of a row against the model
    task automatic scan(input int r);
        int cols[4] = '{0, 15, 16, 1023};
        foreach (cols[k]) begin
            @(posedge ref_clk);
            obsRow <= r[ROW_W-1:0];
            obsCol <= cols[k][COL_W-1:0];
            repeat (2) @(posedge ref_clk);
            #1;
            check(obsCell_q, cellM[r*COLS+cols[k]], "cell");
            check(cell_inverse_drive_q, !cellM[r*COLS+cols[k]], "inverse");
            check(obsTilt_q, tiltM[r*COLS+cols[k]], "tilt");
        end
    endtask
    // Random row over the link, then wait for commit
    task automatic load(input int r);
        logic [COLS-1:0] bits;
        int n;
        for (int k = 0; k < COLS/32; k++)
            bits[32*k +: 32] = $urandom;
        for (int c = 0; c < COLS; c++)
            cellM[r*COLS+c] = bits[c];
        ctrl.send_row(r, bits);
        n = 0;
        while (rowWritten_q !== 1'b1 && n < 30) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(rowWritten_q, 1'b1, "row commit");
    endtask
    // Pulse groups, model mirrors of those groups follow cells
    task automatic fire(input logic [GROUPS-1:0] g);
        ctrl.pulse(g);
        foreach (cellM[i])
            if (g[i/COLS/ROWS_PER_GROUP])
                tiltM[i] = cellM[i];
        check((groupLanded_q & g) == g, 1'b1, "landed");
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        mirrorPark = 1'b0;
        // Park the index outside the array until rows hold data
        obsRow = 10'h3ff;
        obsCol = 10'h000;
        void'($urandom(21524));
        repeat (8) @(posedge ref_clk);
        #1;
        check(cell_inverse_drive_q, 1'b1, "reset inverse");
        rst_n <= 1'b1;
        load(5);
        load(100);
        fire(16'h0005);
        scan(5);
        scan(100);
        load(5);
        load(100);
        scan(5);
        fire(16'h0004);
        scan(5);
        scan(100);
        fire(16'h0001);
        scan(5);
        @(posedge ref_clk);
        mirrorPark <= 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        check(groupLanded_q == 0 && !obsLanded_q, 1'b1, "park");
        tally_and_finish();
    end
endmodule
